// *** uex_pkg.sv ***
// Function
// - Release when reactive power recovers past 97 percent of threshold.
// - Mode setting picks fixed threshold, code 0, or two-point PQ line, code 1.
// - Fixed mode uses first reactive threshold, 0.01 kvar steps, default -100 kvar.
// - Dependent mode uses two PQ points; active power 0.01 kW, default 100 kW.
// - Ratio of measured reactive power to threshold readable, 0.01 resolution.
// - Blocking input sampled at start of each cycle before pick-up evaluation.
// - Pick-up without blocking asserts start and begins trip delay.
// - Pick-up while blocked asserts blocked instead, no timing or trip.
// - Blocking after start drops start and releases as on pick-up dropout.
// - Blocking raises display notice and block event with start power and type.
// - With forcing enabled a software switch drives the blocking input.
// - Definite time: trip after start persists for configured delay.
// - Separate ON and OFF events for start, trip, blocked; stamped with data.
// - One shared enable pair selects ON, OFF or both for main buffer storage of all events.
// - Twelve most recent records kept, oldest overwritten when full.
// - Record on ON events: time, event, pre, fault, pre-fault power, remaining, group.
// - Remaining time to trip readable in 0.005 s steps, counting down.
// - Condition code normal, start, trip, blocked as 0 to 3.
// - Node behaviour on, blocked, test, test-blocked, off as 1 to 5.
// - Selected measurement pairing code 0 to 3, 4 means undefined.
// - Expected operating time readable in 0.005 s steps.
// - Instant mode gives start and trip events together, 1 ms stamps.
// - Resettable cumulative counters of start, trip and blocked.
package uex_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_QSET1 = 8'h04;
  localparam logic [7:0] A_PSET1 = 8'h08;
  localparam logic [7:0] A_SECOND_POINT_REACTIVE_LEVEL = 8'h0C;
  localparam logic [7:0] A_PSET2 = 8'h10;
  localparam logic [7:0] A_DELAY = 8'h14;
  localparam logic [7:0] A_STATUS = 8'h18;
  localparam logic [7:0] A_RATIO = 8'h1C;
  localparam logic [7:0] A_TIMES = 8'h20;
  localparam logic [7:0] A_CNT_ST = 8'h24;
  localparam logic [7:0] A_CNT_TR = 8'h28;
  localparam logic [7:0] A_CNT_BL = 8'h2C;
  localparam logic [7:0] A_HSEL = 8'h30;
  localparam logic [7:0] A_HBASE = 8'h40;
  localparam logic [7:0] A_HLAST = 8'h64;
  // ----------------------------------------
  // Control fields and reset values
  // ----------------------------------------
  localparam int B_MODE = 0;
  localparam int B_INST = 1;
  localparam int B_FEN = 2;
  localparam int B_SWBLK = 3;
  localparam int B_FSTS = 4;
  localparam int B_LN = 8;
  localparam int B_MSEL = 12;
  localparam int B_EON = 16;
  localparam int B_EOFF = 17;
  localparam logic [31:0] CTRL_RST = 32'h0003_0100;
  localparam logic [31:0] QSET_RST = 32'hFFFF_D8F0;
  localparam logic [31:0] PSET_RST = 32'h0000_2710;
  localparam logic [15:0] DELAY_RST = 16'h0014;
  localparam logic [63:0] RR_NUM = 64'h0000_0000_0000_0061;
  localparam logic [63:0] RR_DEN = 64'h0000_0000_0000_0064;
  localparam logic [63:0] RATIO_SCALE = 64'h0000_0000_0000_0064;
  // ----------------------------------------
  // Codes and timing
  // ----------------------------------------
  localparam logic [1:0] C_NORMAL = 2'h0;
  localparam logic [1:0] C_START = 2'h1;
  localparam logic [1:0] C_TRIP = 2'h2;
  localparam logic [1:0] C_BLOCKED = 2'h3;
  localparam logic [2:0] LN_BLK = 3'h2;
  localparam logic [2:0] LN_TSTBLK = 3'h4;
  localparam logic [2:0] LN_OFF = 3'h5;
  localparam logic [2:0] MSEL_UNDEF = 3'h4;
  localparam int CYCLE_MS = 5;
  localparam int PRE_SHORT_MS = 20;
  localparam int PRE_LONG_MS = 200;
  localparam int PRE_SHORT = PRE_SHORT_MS / CYCLE_MS;
  localparam int PRE_LONG = PRE_LONG_MS / CYCLE_MS;
  localparam int HIST_DEPTH = 12;
  typedef enum logic [1:0] {
    UEX_IDLE = 2'b00,
    UEX_RUN = 2'b01,
    UEX_TRIP = 2'b10,
    UEX_BLK = 2'b11
  } uex_state_t;
  typedef struct packed {
    logic valid;
    logic signed [31:0] q;
    logic signed [31:0] p;
  } uex_meas_t;
  typedef struct packed {
    logic start;
    logic trip;
    logic blocked;
    logic disp;
  } uex_out_t;
  typedef struct packed {
    logic [5:0] flags;
    logic [5:0] store;
    logic [31:0] tstamp;
    logic [63:0] pq;
    logic ftype;
  } uex_evt_t;
  typedef struct packed {
    logic [31:0] tstamp;
    logic [2:0] evt;
    logic [63:0] pre_pq;
    logic [63:0] flt_pq;
    logic [63:0] pf_pq;
    logic [15:0] rem;
    logic [2:0] sg;
  } uex_rec_t;
endpackage

// *** uex_stage.sv ***
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
module uex_stage #(
  parameter int HIST_N = uex_pkg::HIST_DEPTH,
  parameter logic [15:0] DELAY_DEF = uex_pkg::DELAY_RST
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire uex_pkg::uex_meas_t meas,
  input wire logic block_in,
  input wire logic [31:0] time_ms,
  input wire logic [2:0] setting_grp,
  output uex_pkg::uex_out_t stage_out,
  output uex_pkg::uex_evt_t evt
);
  import uex_pkg::*;

  // ----------------------------------------
  // State record
  // ----------------------------------------
  typedef struct packed {
    logic blk_m;
    logic blk_s;
    logic [31:0] ctrl;
    logic [31:0] qset1;
    logic [31:0] pset1;
    logic [31:0] second_point_reactive_level;
    logic [31:0] pset2;
    logic [15:0] delay;
    logic [3:0] hsel;
    uex_state_t st;
    logic [15:0] cnt;
    logic [31:0] ratio;
    logic [63:0] flt_pq;
    logic [63:0] pf_pq;
    logic [2:0][31:0] tally;
    logic [PRE_LONG-1:0][63:0] pq_line;
    uex_rec_t [HIST_N-1:0] hist;
    logic [3:0] hwr;
    logic [3:0] hcnt;
    logic [31:0] rdata;
    uex_out_t out;
    uex_evt_t ev;
  } st_t;

  st_t s_r;
  st_t s_nxt;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // ON/OFF pair for one output: bit0 rising, bit1 falling
  function automatic logic [1:0] edge_pair(input logic was, input logic now);
    edge_pair = {was & ~now, ~was & now};
  endfunction

  // Scale a threshold to the release level
  function automatic logic signed [31:0] rel_lvl(input logic signed [31:0] q);
    logic signed [63:0] w;
    w = (64'(q) * $signed(RR_NUM)) / $signed(RR_DEN);
    rel_lvl = w[31:0];
  endfunction

  // History slot of the n-th newest record
  function automatic logic [3:0] slot(input logic [3:0] wr, input logic [3:0] n);
    logic [4:0] t;
    t = {1'b0, wr} + 5'(HIST_N) - 5'd1 - {1'b0, n};
    if (t >= 5'(HIST_N)) begin
      t = t - 5'(HIST_N);
    end
    slot = t[3:0];
  endfunction

  // ----------------------------------------
  // Combinational decode
  // ----------------------------------------
  logic mode_dep;
  logic inst;
  logic fen;
  logic [1:0] fsts;
  logic [2:0] ln;
  logic [2:0] msel;
  logic held;
  logic signed [31:0] q1h;
  logic signed [31:0] q2h;
  logic signed [63:0] lhs;
  logic signed [63:0] rhs;
  logic signed [31:0] dp;
  logic pickup;
  logic blk_now;
  logic [1:0] cond;
  logic [15:0] remain;
  logic [15:0] expect_t;
  logic acc;
  logic setup;
  logic hit;
  logic [3:0] rsel;
  uex_rec_t rrec;

  always_comb begin
    mode_dep = s_r.ctrl[B_MODE];
    inst = s_r.ctrl[B_INST];
    fen = s_r.ctrl[B_FEN];
    fsts = s_r.ctrl[B_FSTS +: 2];
    ln = s_r.ctrl[B_LN +: 3];
    msel = (s_r.ctrl[B_MSEL +: 3] > 3'h3) ? MSEL_UNDEF : s_r.ctrl[B_MSEL +: 3];
    held = (s_r.st != UEX_IDLE);
    // Once held, thresholds move toward zero, giving hysteresis
    q1h = held ? rel_lvl(s_r.qset1) : s_r.qset1;
    q2h = held ? rel_lvl(s_r.second_point_reactive_level) : s_r.second_point_reactive_level;
    dp = s_r.pset2 - s_r.pset1;
    lhs = 64'(meas.q - q1h) * 64'(dp);
    rhs = 64'(q2h - q1h) * 64'(meas.p - $signed(s_r.pset1));
    // Below the line means more capacitive; orientation follows dp sign
    if (mode_dep) begin
      pickup = (dp >= 0) ? (lhs <= rhs) : (lhs >= rhs);
    end else begin
      pickup = meas.q <= q1h;
    end
    if (ln == LN_OFF) begin
      pickup = 1'b0;
    end
    // Blocking from synchronised pin, forced switch or node mode
    blk_now = s_r.blk_s | (fen & s_r.ctrl[B_SWBLK]) | (ln == LN_BLK) | (ln == LN_TSTBLK);
    cond = s_r.out.trip ? C_TRIP : s_r.out.start ? C_START : s_r.out.blocked ? C_BLOCKED
      : C_NORMAL;
    remain = (s_r.out.start && !s_r.out.trip) ? (s_r.delay - s_r.cnt) : 16'h0000;
    expect_t = inst ? 16'h0000 : s_r.delay;
    setup = psel & ~penable;
    acc = psel & penable;
    hit = (paddr[1:0] == 2'b00) && ((paddr <= A_HSEL) || ((paddr >= A_HBASE)
      && (paddr <= A_HLAST)));
    rsel = slot(s_r.hwr, s_r.hsel);
    rrec = s_r.hist[rsel];
  end

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  // Read data is captured in setup so it stands registered in access
  assign pready = acc;
  assign pslverr = acc & ~hit;
  assign prdata = s_r.rdata;
  assign stage_out = s_r.out;
  assign evt = s_r.ev;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic st_n;
    logic tr_n;
    logic bl_n;
    logic [5:0] fl;
    logic signed [63:0] rq;
    uex_rec_t rec;
    st_n = 1'b0;
    tr_n = 1'b0;
    bl_n = 1'b0;
    fl = 6'h00;
    rq = 64'h0;
    rec = '0;
    s_nxt = s_r;
    s_nxt.ev.flags = 6'h00;
    s_nxt.ev.store = 6'h00;
    s_nxt.out.disp = 1'b0;
    // Pin synchroniser; only the second stage is read
    s_nxt.blk_m = block_in;
    s_nxt.blk_s = s_r.blk_m;

    // Register read capture
    if (setup && !pwrite) begin
      case (paddr)
        A_CTRL: s_nxt.rdata = s_r.ctrl;
        A_QSET1: s_nxt.rdata = s_r.qset1;
        A_PSET1: s_nxt.rdata = s_r.pset1;
        A_SECOND_POINT_REACTIVE_LEVEL: s_nxt.rdata = s_r.second_point_reactive_level;
        A_PSET2: s_nxt.rdata = s_r.pset2;
        A_DELAY: s_nxt.rdata = {16'h0000, s_r.delay};
        A_STATUS: s_nxt.rdata = {21'h0, msel, 1'b0, ln, 2'b00, cond};
        A_RATIO: s_nxt.rdata = s_r.ratio;
        A_TIMES: s_nxt.rdata = {remain, expect_t};
        A_CNT_ST: s_nxt.rdata = s_r.tally[0];
        A_CNT_TR: s_nxt.rdata = s_r.tally[1];
        A_CNT_BL: s_nxt.rdata = s_r.tally[2];
        A_HSEL: s_nxt.rdata = {20'h0, s_r.hcnt, 4'h0, s_r.hsel};
        8'h40: s_nxt.rdata = rrec.tstamp;
        8'h44: s_nxt.rdata = {29'h0, rrec.evt};
        8'h48: s_nxt.rdata = rrec.pre_pq[63:32];
        8'h4C: s_nxt.rdata = rrec.pre_pq[31:0];
        8'h50: s_nxt.rdata = rrec.flt_pq[63:32];
        8'h54: s_nxt.rdata = rrec.flt_pq[31:0];
        8'h58: s_nxt.rdata = rrec.pf_pq[63:32];
        8'h5C: s_nxt.rdata = rrec.pf_pq[31:0];
        8'h60: s_nxt.rdata = {16'h0000, rrec.rem};
        A_HLAST: s_nxt.rdata = {29'h0, rrec.sg};
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // Register writes; a counter clears on any write to its own address
    if (acc && pwrite) begin
      case (paddr)
        A_CTRL: s_nxt.ctrl = pwdata;
        A_QSET1: s_nxt.qset1 = pwdata;
        A_PSET1: s_nxt.pset1 = pwdata;
        A_SECOND_POINT_REACTIVE_LEVEL: s_nxt.second_point_reactive_level = pwdata;
        A_PSET2: s_nxt.pset2 = pwdata;
        A_DELAY: s_nxt.delay = pwdata[15:0];
        A_CNT_ST: s_nxt.tally[0] = 32'h0000_0000;
        A_CNT_TR: s_nxt.tally[1] = 32'h0000_0000;
        A_CNT_BL: s_nxt.tally[2] = 32'h0000_0000;
        A_HSEL: s_nxt.hsel = (pwdata[3:0] >= 4'(HIST_N)) ? 4'h0 : pwdata[3:0];
        default: ;
      endcase
    end

    // Program cycle, one per measurement strobe
    if (meas.valid) begin
      s_nxt.pq_line = {s_r.pq_line[PRE_LONG-2:0], {meas.p, meas.q}};
      if (s_r.qset1 != 32'h0000_0000) begin
        rq = (64'(meas.q) * $signed(RATIO_SCALE)) / 64'($signed(s_r.qset1));
      end
      s_nxt.ratio = rq[31:0];
      // Block level taken before the pick-up result is used
      case (s_r.st)
        UEX_IDLE, UEX_RUN, UEX_TRIP, UEX_BLK: begin
          if (!pickup) begin
            s_nxt.st = UEX_IDLE;
            s_nxt.cnt = 16'h0000;
          end else if (blk_now) begin
            s_nxt.st = UEX_BLK;
            s_nxt.cnt = 16'h0000;
          end else if (s_r.st == UEX_IDLE || s_r.st == UEX_BLK) begin
            s_nxt.cnt = 16'h0001;
            s_nxt.st = (inst || s_r.delay <= 16'h0001) ? UEX_TRIP : UEX_RUN;
          end else if (s_r.st == UEX_RUN) begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
            if (s_nxt.cnt >= s_r.delay) begin
              s_nxt.st = UEX_TRIP;
            end
          end
        end
        default: s_nxt.st = UEX_IDLE;
      endcase
      st_n = (s_nxt.st == UEX_RUN) || (s_nxt.st == UEX_TRIP);
      tr_n = s_nxt.st == UEX_TRIP;
      bl_n = s_nxt.st == UEX_BLK;
      // Forced status other than normal wins over measurement while forcing is enabled
      if (fen && fsts != C_NORMAL) begin
        st_n = (fsts == C_START) || (fsts == C_TRIP);
        tr_n = fsts == C_TRIP;
        bl_n = fsts == C_BLOCKED;
      end
      s_nxt.out.start = st_n;
      s_nxt.out.trip = tr_n;
      s_nxt.out.blocked = bl_n;
      fl = {edge_pair(s_r.out.blocked, bl_n), edge_pair(s_r.out.trip, tr_n),
        edge_pair(s_r.out.start, st_n)};
      // Fault power frozen at start or block onset
      if (fl[0] || fl[4]) begin
        s_nxt.flt_pq = {meas.p, meas.q};
        s_nxt.pf_pq = s_r.pq_line[PRE_LONG-1];
      end
      for (int i = 0; i < 3; i++) begin
        if (fl[2*i]) begin
          s_nxt.tally[i] = s_nxt.tally[i] + 32'h0000_0001;
        end
      end
      s_nxt.out.disp = fl[4];
      // Same stamp for every event of one cycle
      s_nxt.ev.flags = fl;
      s_nxt.ev.store = fl & {3{s_r.ctrl[B_EOFF], s_r.ctrl[B_EON]}};
      s_nxt.ev.tstamp = time_ms;
      s_nxt.ev.pq = s_nxt.flt_pq;
      s_nxt.ev.ftype = mode_dep;
      // One history record per cycle holding any ON event
      if (fl[0] || fl[2] || fl[4]) begin
        rec.tstamp = time_ms;
        rec.evt = {fl[4], fl[2], fl[0]};
        rec.pre_pq = s_r.pq_line[PRE_SHORT-1];
        rec.flt_pq = s_nxt.flt_pq;
        rec.pf_pq = s_nxt.pf_pq;
        rec.rem = (st_n && !tr_n) ? (s_r.delay - s_nxt.cnt) : 16'h0000;
        rec.sg = setting_grp;
        s_nxt.hist[s_r.hwr] = rec;
        s_nxt.hwr = (s_r.hwr == 4'(HIST_N - 1)) ? 4'h0 : s_r.hwr + 4'h1;
        if (s_r.hcnt != 4'(HIST_N)) begin
          s_nxt.hcnt = s_r.hcnt + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Reset loads constants only; thresholds come up at documented defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.ctrl <= CTRL_RST;
      s_r.qset1 <= QSET_RST;
      s_r.second_point_reactive_level <= QSET_RST;
      s_r.pset1 <= PSET_RST;
      s_r.pset2 <= PSET_RST;
      s_r.delay <= DELAY_DEF;
      s_r.st <= UEX_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// *** uex_stage_chk_asserts.sv ***
`timescale 1ns/1ps
module uex_stage_chk #(
  parameter int HIST_N = uex_pkg::HIST_DEPTH,
  parameter logic [15:0] DELAY_DEF = uex_pkg::DELAY_RST
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire uex_pkg::uex_meas_t meas,
  input wire logic block_in,
  input wire logic [31:0] time_ms,
  input wire logic [2:0] setting_grp,
  input wire uex_pkg::uex_out_t stage_out,
  input wire uex_pkg::uex_evt_t evt
);
  import uex_pkg::*;
  // --------------------
  // Output relations
  // --------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_start_on;
    $rose(stage_out.start) |-> evt.flags[0] && $past(meas.valid) ##1 !evt.flags[0];
  endproperty
  a_start_on: assert property (p_start_on) else $error("start rose badly");
  property p_start_off;
    $fell(stage_out.start) |-> evt.flags[1];
  endproperty
  a_start_off: assert property (p_start_off) else $error("no start off event");
  property p_trip_on;
    $rose(stage_out.trip) |-> evt.flags[2] && $past(meas.valid);
  endproperty
  a_trip_on: assert property (p_trip_on) else $error("trip rose badly");
  property p_blk_on;
    $rose(stage_out.blocked) |-> evt.flags[4] && !stage_out.start;
  endproperty
  a_blk_on: assert property (p_blk_on) else $error("blocked rose badly");
  property p_blk_off;
    $fell(stage_out.blocked) |-> evt.flags[5];
  endproperty
  a_blk_off: assert property (p_blk_off) else $error("no block off event");
  property p_disp;
    $rose(stage_out.blocked) |-> stage_out.disp ##1 !stage_out.disp;
  endproperty
  a_disp: assert property (p_disp) else $error("display notice missing");
  // Levels may move only on the cycle after a strobe
  property p_hold;
    !$past(meas.valid) |-> $stable({stage_out.start, stage_out.trip, stage_out.blocked});
  endproperty
  a_hold: assert property (p_hold) else $error("output moved off strobe");
  property p_store;
    evt.store != 6'h00 |-> (evt.store & ~evt.flags) == 6'h00;
  endproperty
  a_store: assert property (p_store) else $error("stored event not raised");
  // Every event of one strobe carries the time taken at that strobe
  property p_stamp;
    evt.flags != 6'h00 |-> evt.tstamp == $past(time_ms);
  endproperty
  a_stamp: assert property (p_stamp) else $error("event stamp off");
  property p_apb;
    pready == (psel && penable) && (!pslverr || pready);
  endproperty
  a_apb: assert property (p_apb) else $error("bus answer out of step");
endmodule

bind uex_stage uex_stage_chk #(.HIST_N(HIST_N), .DELAY_DEF(DELAY_DEF)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .meas(meas), .block_in(block_in), .time_ms(time_ms), .setting_grp(setting_grp),
  .stage_out(stage_out), .evt(evt)
);

// *** uex_meas_src.sv ***
`timescale 1ns/1ps
module uex_meas_src (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] gap,
  input wire logic signed [31:0] q_in,
  input wire logic signed [31:0] p_in,
  input wire logic blk_cmd,
  output uex_pkg::uex_meas_t meas,
  output logic block_in,
  output logic [31:0] time_ms
);
  import uex_pkg::*;
  logic [7:0] cnt_r;
  logic vld_r;
  // Strobe every gap+1 cycles; a short gap stands in for the program cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
      vld_r <= 1'b0;
      time_ms <= 32'h0000_0000;
      block_in <= 1'b0;
    end else begin
      vld_r <= (cnt_r == gap);
      cnt_r <= (cnt_r == gap) ? 8'h00 : cnt_r + 8'h01;
      if (vld_r) begin
        time_ms <= time_ms + 32'(CYCLE_MS);
      end
      block_in <= blk_cmd;
    end
  end
  // Between strobes the lines carry junk, so a held sample is never trusted
  assign meas = '{valid: vld_r, q: vld_r ? q_in : ~q_in, p: vld_r ? p_in : ~p_in};
endmodule

// *** uex_stage_tb_top.sv ***
`timescale 1ns/1ps
module uex_stage_tb_top;
  import uex_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  uex_meas_t meas;
  uex_out_t stage_out;
  uex_evt_t evt;
  logic block_in;
  logic [31:0] time_ms;
  logic [2:0] setting_grp = 3'h5;
  logic signed [31:0] q_in = 32'sh0;
  logic blk = 1'b0;
  logic [31:0] lfsr = 32'h2851;
  logic [32:0] rd_q[$];
  logic [11:0] ev_q[$];
  int errors = 0;
  int num_checks = 0;
  int r;
  always #5 pclk = ~pclk;
  uex_stage dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas(meas), .block_in(block_in), .time_ms(time_ms),
    .setting_grp(setting_grp), .stage_out(stage_out), .evt(evt));
  uex_meas_src src_u (.pclk(pclk), .presetn(presetn), .gap(8'h07), .q_in(q_in),
    .p_in(32'sh0000_2710), .blk_cmd(blk), .meas(meas), .block_in(block_in),
    .time_ms(time_ms));
  // --------------------
  // Bus, scoreboard and closing
  // --------------------
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Hold the request until pready is seen; the watchdog ends a hang
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic ev(input logic [5:0] f, input logic [5:0] s);
    ev_q.push_back({f, s});
  endtask
  task automatic strobes(input int k);
    repeat (k) @(posedge pclk iff meas.valid === 1'b1);
  endtask
  task automatic chk_rd(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_ev(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    // A note never matched by a result means a missing read or event
    if (rd_q.size() != 0 || ev_q.size() != 0) begin
      errors++;
    end
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Each result is held against the oldest note of its kind
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      chk_rd({pslverr, prdata}, rd_q.pop_front());
    end
    if (evt.flags !== 6'h00) begin
      chk_ev({evt.flags, evt.store}, ev_q.pop_front());
    end
  end
  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge pclk);
    errors++;
    summarize();
  end
  // --------------------
  // Tests
  // --------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(A_CTRL, {1'b0, CTRL_RST});
    rd(A_QSET1, {1'b0, QSET_RST});
    rd(A_SECOND_POINT_REACTIVE_LEVEL, {1'b0, QSET_RST});
    rd(A_PSET1, {1'b0, PSET_RST});
    rd(A_DELAY, {17'h0_0000, DELAY_RST});
    rd(8'h38, 33'h1_0000_0000);
    $display("reset values done");
    apb(1'b1, A_DELAY, 32'h0000_0003);
    strobes(1);
    q_in <= -32'sd15000;
    ev(6'h01, 6'h01);
    ev(6'h04, 6'h04);
    strobes(4);
    rd(A_STATUS, {1'b0, 32'h0000_0012});
    $display("definite time trip done");
    // Drop OFF storage; between threshold and 97 percent the stage must hold
    apb(1'b1, A_CTRL, 32'h0001_0100);
    q_in <= -32'sd9800;
    strobes(2);
    q_in <= -32'sd9600;
    ev(6'h0A, 6'h00);
    strobes(2);
    apb(1'b1, A_CTRL, CTRL_RST);
    $display("release level done");
    blk <= 1'b1;
    strobes(1);
    q_in <= -32'sd15000;
    ev(6'h10, 6'h10);
    strobes(2);
    q_in <= 32'sh0;
    ev(6'h20, 6'h20);
    strobes(2);
    blk <= 1'b0;
    $display("blocking done");
    rd(A_CNT_ST, 33'h1);
    rd(A_CNT_TR, 33'h1);
    rd(A_CNT_BL, 33'h1);
    apb(1'b1, A_CNT_ST, 32'h0000_0000);
    rd(A_CNT_ST, 33'h0);
    rd(A_HSEL, {1'b0, 32'h0000_0300});
    rd(8'h44, 33'h4);
    rd(8'h54, {1'b0, 32'hFFFF_C568});
    rd(A_HLAST, {30'h0, setting_grp});
    $display("counters and history done");
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, A_CTRL, 32'(i << 12 | (i % 5 + 1) << 8) | 32'h0003_0000);
      rd(A_STATUS, 33'((i > 3 ? 4 : i) << 8 | (i % 5 + 1) << 4));
    end
    apb(1'b1, A_CTRL, CTRL_RST);
    $display("status codes done");
    // Random levels stay above the release level so nothing picks up
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      r = int'(lfsr % 9000) + 1;
      q_in <= -r;
      strobes(2);
      rd(A_RATIO, 33'(r * 100 / 10000));
    end
    $display("ratio done");
    // Blocking while timing drops start; forced trip then wins as the block switch is cleared
    q_in <= -32'sd15000;
    ev(6'h01, 6'h01);
    strobes(2);
    rd(A_TIMES, 33'h0_0001_0003);
    apb(1'b1, A_CTRL, CTRL_RST | 32'h0000_000C);
    ev(6'h12, 6'h12);
    strobes(2);
    apb(1'b1, A_CTRL, CTRL_RST | 32'h0000_0024);
    ev(6'h25, 6'h25);
    strobes(2);
    q_in <= 32'sh0;
    apb(1'b1, A_CTRL, CTRL_RST);
    ev(6'h0A, 6'h0A);
    strobes(2);
    $display("blocking after start and forcing done");
    // Line through (0 kW, -100 kvar) and (200 kW, -140 kvar): -110 kvar stays clear
    apb(1'b1, A_PSET1, 32'h0000_0000);
    apb(1'b1, A_SECOND_POINT_REACTIVE_LEVEL, 32'hFFFF_C950);
    apb(1'b1, A_PSET2, 32'h0000_4E20);
    apb(1'b1, A_CTRL, CTRL_RST | 32'h0000_0003);
    q_in <= -32'sd11000;
    strobes(2);
    q_in <= -32'sd13000;
    ev(6'h05, 6'h05);
    strobes(2);
    q_in <= 32'sh0;
    ev(6'h0A, 6'h0A);
    strobes(2);
    $display("line mode and instant trip done");
    summarize();
  end
endmodule
